// ===== pmac_chk.sv
// Checker for the memory access interpreter ports
`timescale 1ns/1ps
module pmac_chk #(
    parameter int INIT_CYCLES = 4
) (
    // Clock and reset
    input wire logic                        CLK_SYS,
    input wire logic                        RST,
    // Host side
    input wire logic                        RX_READY,
    input wire logic                        TX_VALID,
    input wire logic [7:0]                  TX_DATA,
    input wire logic                        TX_READY,
    // Memory side
    input wire logic                        MEM_REQ,
    input wire logic                        MEM_WE,
    input wire logic [pmac_pkg::ROW_W-1:0]  MEM_ROW,
    input wire logic [pmac_pkg::COL_W-1:0]  MEM_COL,
    input wire logic [31:0]                 MEM_WDATA,
    input wire logic                        MEM_ACK,
    input wire logic                        MEM_READY
);
    default clocking cb @(posedge CLK_SYS); endclocking
    default disable iff (RST);
    logic [7:0] wd0;
    assign wd0 = MEM_WDATA[8*MEM_COL[1:0] +: 8];
    // Idle sender only, so the reply head is the first byte
    sequence s_rd_ack; MEM_REQ && !MEM_WE && MEM_ACK && !TX_VALID; endsequence
    sequence s_wr_ack; MEM_REQ && MEM_WE && MEM_ACK && !TX_VALID; endsequence
    property p_req_hold; MEM_REQ && !MEM_ACK |=> MEM_REQ && $stable(MEM_COL); endproperty
    a_req_hold: assert property (p_req_hold) else $error("request dropped");
    property p_req_drop; MEM_REQ && MEM_ACK |=> !MEM_REQ; endproperty
    a_req_drop: assert property (p_req_drop) else $error("request repeated");
    property p_rx_block; MEM_REQ |-> !RX_READY; endproperty
    a_rx_block: assert property (p_rx_block) else $error("byte taken in access");
    property p_tx_hold; TX_VALID && !TX_READY |=> TX_VALID && $stable(TX_DATA); endproperty
    a_tx_hold: assert property (p_tx_hold) else $error("reply byte lost");
    property p_req_init; MEM_REQ |-> MEM_READY; endproperty
    a_req_init: assert property (p_req_init) else $error("access before init");
    property p_ready_stay; MEM_READY |=> MEM_READY; endproperty
    a_ready_stay: assert property (p_ready_stay) else $error("ready fell");
    property p_rd_cmd; s_rd_ack |-> ##2 TX_VALID && TX_DATA == {7'h40, $past(MEM_ROW[12], 2)};
    endproperty
    a_rd_cmd: assert property (p_rd_cmd) else $error("read reply head wrong");
    property p_wr_first; s_wr_ack |-> ##2 TX_VALID && TX_DATA == $past(wd0, 2); endproperty
    a_wr_first: assert property (p_wr_first) else $error("write echo head wrong");
endmodule : pmac_chk

// ===== pmac_core.sv
// Packet interpreter for memory read, write and initialise commands
`timescale 1ns/1ps
// Function
// - Every memory access moves exactly four bytes
// - Low column bits rotate within the group
// - Read command 0x80, lsb is row top
// - Write command 0x90, lsb is row top
// - Second byte holds middle row bits
// - Third byte: low row, upper column nibble
// - Fourth byte: low column bits, then bank
// - Write uses same address layout as read
// - Write carries four data bytes, offsets 0-3
// - Write echoes data, then command and address
// - Uninitialised read returns 0xE7, then invalid data 0x00
// - Uninitialised write echoes 0xE7 for command
// - Memory usable only after init command
module pmac_core #(
    parameter int INIT_CYCLES = pmac_pkg::INIT_CYCLES
) (
    // Clock and reset
    input  wire logic                     CLK_SYS,
    input  wire logic                     RST,
    // Host byte stream in
    input  wire logic                     RX_VALID,
    input  wire logic [7:0]               RX_DATA,
    output logic                          RX_READY,
    // Host byte stream out
    output logic                          TX_VALID,
    output logic [7:0]                    TX_DATA,
    input  wire logic                     TX_READY,
    // Memory burst port
    output logic                          MEM_REQ,
    output logic                          MEM_WE,
    output logic [pmac_pkg::BANK_W-1:0]   MEM_BANK,
    output logic [pmac_pkg::ROW_W-1:0]    MEM_ROW,
    output logic [pmac_pkg::COL_W-1:0]    MEM_COL,
    output logic [31:0]                   MEM_WDATA,
    input  wire logic                     MEM_ACK,
    input  wire logic [31:0]              MEM_RDATA,
    // Status
    output logic                          MEM_READY
);
    pmac_pkg::pmac_state_t state;
    pmac_pkg::pmac_state_t next_state;
    logic [7:0]  cmd;
    logic [7:0]  next_cmd;
    logic [23:0] addr;
    logic [23:0] next_addr;
    logic [31:0] data;
    logic [31:0] next_data;
    logic [2:0]  idx;
    logic [2:0]  next_idx;
    logic        inited;
    logic        next_inited;
    logic [31:0] init_cnt;
    logic [31:0] next_init_cnt;
    logic        req;
    logic        next_req;
    logic        rx_ready;
    logic        next_rx_ready;
    logic        load;
    logic [63:0] load_bytes;
    logic [3:0]  load_count;
    logic        tx_busy;

    // Rotate a four-byte group so byte k lands at column (start + k) mod 4
    function automatic logic [31:0] pmac_rotate(input logic [31:0] d, input logic [1:0] s);
        logic [63:0] dd;
        dd = {d, d};
        pmac_rotate = 32'(dd >> (32 - 8 * int'(s)));
    endfunction : pmac_rotate

    // Inverse of the rotation, used on read data
    function automatic logic [31:0] pmac_unrotate(input logic [31:0] d, input logic [1:0] s);
        logic [63:0] dd;
        dd = {d, d};
        pmac_unrotate = 32'(dd >> (8 * int'(s)));
    endfunction : pmac_unrotate

    logic rx_take;
    assign rx_take = RX_VALID && RX_READY;

    always_comb begin
        next_state    = state;
        next_cmd      = cmd;
        next_addr     = addr;
        next_data     = data;
        next_idx      = idx;
        next_inited   = inited;
        next_init_cnt = init_cnt;
        next_req      = req;
        load          = 1'b0;
        load_bytes    = '0;
        load_count    = 4'h0;
        case (state)
            pmac_pkg::PMAC_IDLE: begin
                if (rx_take) begin
                    next_cmd = RX_DATA;
                    next_idx = 3'h1;
                    if (RX_DATA[7:1] == pmac_pkg::CMD_READ[7:1] ||
                        RX_DATA[7:1] == pmac_pkg::CMD_WRITE[7:1]) begin
                        next_state = pmac_pkg::PMAC_ADDR;
                    end else if (RX_DATA == pmac_pkg::CMD_INIT) begin
                        next_inited   = 1'b0;
                        next_init_cnt = 32'(INIT_CYCLES);
                        next_state    = pmac_pkg::PMAC_INIT;
                    end
                end
            end
            pmac_pkg::PMAC_INIT: begin
                // Calibration wait; other commands are held off meanwhile
                if (init_cnt <= 32'h1) begin
                    next_inited = 1'b1;
                    next_state  = pmac_pkg::PMAC_IDLE;
                end else begin
                    next_init_cnt = init_cnt - 32'h1;
                end
            end
            pmac_pkg::PMAC_ADDR: begin
                if (rx_take) begin
                    next_addr = {addr[15:0], RX_DATA};
                    next_idx  = idx + 3'h1;
                    if (idx == pmac_pkg::LAST_ADDR) begin
                        if (cmd[7:1] == pmac_pkg::CMD_WRITE[7:1]) begin
                            next_state = pmac_pkg::PMAC_DATA;
                        end else begin
                            next_req   = inited;
                            next_state = inited ? pmac_pkg::PMAC_MEM : pmac_pkg::PMAC_SEND;
                        end
                    end
                end
            end
            pmac_pkg::PMAC_DATA: begin
                if (rx_take) begin
                    next_data = {RX_DATA, data[31:8]};
                    next_idx  = idx + 3'h1;
                    if (idx == pmac_pkg::LAST_DATA) begin
                        next_req   = inited;
                        next_state = inited ? pmac_pkg::PMAC_MEM : pmac_pkg::PMAC_SEND;
                    end
                end
            end
            pmac_pkg::PMAC_MEM: begin
                if (MEM_ACK) begin
                    next_req = 1'b0;
                    if (cmd[7:1] == pmac_pkg::CMD_READ[7:1]) begin
                        next_data = pmac_unrotate(MEM_RDATA, addr[3:2]);
                    end
                    next_state = pmac_pkg::PMAC_SEND;
                end
            end
            pmac_pkg::PMAC_SEND: begin
                if (!tx_busy) begin
                    load = 1'b1;
                    if (cmd[7:1] == pmac_pkg::CMD_WRITE[7:1]) begin
                        // Data, then command (or error) and three address bytes
                        load_bytes = {addr[7:0], addr[15:8], addr[23:16],
                                      inited ? cmd : pmac_pkg::CMD_ERR, data};
                        load_count = 4'h8;
                    end else begin
                        // Status byte leads so the host can discard bad data
                        load_bytes = {24'h0, inited ? data : {4{pmac_pkg::INVALID_DATA}},
                                      inited ? cmd : pmac_pkg::CMD_ERR};
                        load_count = 4'h5;
                    end
                    next_state = pmac_pkg::PMAC_IDLE;
                end
            end
            default: next_state = pmac_pkg::PMAC_IDLE;
        endcase
        // Registered so the host sees a clean level straight from a flop
        next_rx_ready = (next_state == pmac_pkg::PMAC_IDLE) ||
                        (next_state == pmac_pkg::PMAC_ADDR) ||
                        (next_state == pmac_pkg::PMAC_DATA);
    end

    always_ff @(posedge CLK_SYS or posedge RST) begin
        if (RST) begin
            state    <= pmac_pkg::PMAC_IDLE;
            cmd      <= 8'h00;
            addr     <= 24'h000000;
            data     <= 32'h00000000;
            idx      <= 3'h0;
            inited   <= 1'b0;
            init_cnt <= 32'h00000000;
            req      <= 1'b0;
            rx_ready <= 1'b1;
        end else begin
            state    <= next_state;
            cmd      <= next_cmd;
            addr     <= next_addr;
            data     <= next_data;
            idx      <= next_idx;
            inited   <= next_inited;
            init_cnt <= next_init_cnt;
            req      <= next_req;
            rx_ready <= next_rx_ready;
        end
    end

    // Receive only while gathering a packet; back-pressure otherwise
    assign RX_READY  = rx_ready;
    assign MEM_REQ   = req;
    assign MEM_WE    = cmd[4];
    assign MEM_ROW   = {cmd[0], addr[23:16], addr[15:12]};
    assign MEM_COL   = {addr[11:8], addr[7:2]};
    assign MEM_BANK  = addr[1:0];
    assign MEM_WDATA = pmac_rotate(data, addr[3:2]);
    assign MEM_READY = inited;

    pmac_tx #(
        .DEPTH      (8)
    ) u_tx (
        .clk        (CLK_SYS),
        .rst        (RST),
        .load       (load),
        .load_bytes (load_bytes),
        .load_count (load_count),
        .busy       (tx_busy),
        .tx_valid   (TX_VALID),
        .tx_data    (TX_DATA),
        .tx_ready   (TX_READY)
    );
endmodule : pmac_core

// ===== pmac_mem.sv
// Behavioural burst memory answering the interpreter
`timescale 1ns/1ps
module pmac_mem (
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        rst,
    // Request side
    input  wire logic [2:0]  lat,
    input  wire logic        req,
    input  wire logic        we,
    input  wire logic [1:0]  bank,
    input  wire logic [12:0] row,
    input  wire logic [9:0]  col,
    input  wire logic [31:0] wdata,
    // Answer side
    output logic             ack,
    output logic [31:0]      rdata
);
    logic [31:0] store[int];
    int          cnt;
    int          a;
    assign a = {bank, row, col[9:2]};
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            ack <= 1'b0;
            rdata <= 32'h0;
            cnt <= 0;
        end else begin
            ack <= 1'b0;
            // Data is only good with ack
            rdata <= ~rdata;
            if (req && !ack) begin
                if (cnt >= lat) begin
                    cnt <= 0;
                    ack <= 1'b1;
                    if (we) store[a] = wdata;
                    rdata <= store.exists(a) ? store[a] : 32'h0;
                end else cnt <= cnt + 1;
            end
        end
    end
endmodule : pmac_mem

// ===== pmac_pkg.sv
// Package with command codes, packet layout and timing counts for the memory access interpreter
package pmac_pkg;
    // Command bytes (upper seven bits select read or write; init must match all eight bits)
    localparam logic [7:0] CMD_READ     = 8'h80;
    localparam logic [7:0] CMD_WRITE    = 8'h90;
    localparam logic [7:0] CMD_INIT     = 8'h70;
    localparam logic [7:0] CMD_ERR      = 8'he7;
    localparam logic [6:0] CMD_MASK_TOP = 7'h7f;
    // Burst and packet sizes
    localparam int         BURST_LEN    = 4;
    localparam int         ADDR_BYTES   = 3;
    localparam logic [2:0] LAST_ADDR    = 3'h3;
    localparam logic [2:0] LAST_DATA    = 3'h7;
    // Address field widths and positions
    localparam int ROW_W  = 13;
    localparam int COL_W  = 10;
    localparam int BANK_W = 2;
    localparam int NIB_HI = 4;
    localparam int COL_LO = 2;
    // Fill value for reads of uninitialised memory
    localparam logic [7:0] INVALID_DATA = 8'h00;
    // Initialisation delay of the memory
    localparam int INIT_TIME_NS = 200000;
    localparam int CLK_NS       = 25;
    localparam int INIT_CYCLES  = INIT_TIME_NS / CLK_NS;
    // Interpreter states
    typedef enum logic [2:0] {
        PMAC_IDLE  = 3'b000,
        PMAC_ADDR  = 3'b001,
        PMAC_DATA  = 3'b010,
        PMAC_MEM   = 3'b011,
        PMAC_SEND  = 3'b100,
        PMAC_INIT  = 3'b101
    } pmac_state_t;
endpackage : pmac_pkg

// ===== pmac_tx.sv
// Reply sender: shifts out a prepared byte list, one byte per accepted handshake
`timescale 1ns/1ps
module pmac_tx #(
    parameter int DEPTH = 8
) (
    // Clock and reset
    input  wire logic                     clk,
    input  wire logic                     rst,
    // Load side
    input  wire logic                     load,
    input  wire logic [DEPTH*8-1:0]       load_bytes,
    input  wire logic [3:0]               load_count,
    output logic                          busy,
    // Byte side
    output logic                          tx_valid,
    output logic [7:0]                    tx_data,
    input  wire logic                     tx_ready
);
    logic [DEPTH*8-1:0] sreg;
    logic [DEPTH*8-1:0] next_sreg;
    logic [3:0]         left;
    logic [3:0]         next_left;

    always_comb begin
        next_sreg = sreg;
        next_left = left;
        if (load && left == 4'h0) begin
            next_sreg = load_bytes;
            next_left = load_count;
        end else if (left != 4'h0 && tx_ready) begin
            next_sreg = {8'h00, sreg[DEPTH*8-1:8]};
            next_left = left - 4'h1;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            sreg <= '0;
            left <= 4'h0;
        end else begin
            sreg <= next_sreg;
            left <= next_left;
        end
    end

    assign busy     = (left != 4'h0);
    assign tx_valid = (left != 4'h0);
    assign tx_data  = sreg[7:0];
endmodule : pmac_tx

// ===== tb.sv
// Testbench for the memory access interpreter
`timescale 1ns/1ps
module tb;
    logic CLK_SYS = 0, RST = 1, RX_VALID = 0, TX_READY = 0;
    logic RX_READY, TX_VALID, MEM_REQ, MEM_WE, MEM_ACK, MEM_READY;
    logic [7:0] RX_DATA = 8'h00, TX_DATA;
    logic [1:0] MEM_BANK;
    logic [12:0] MEM_ROW;
    logic [9:0] MEM_COL;
    logic [31:0] MEM_WDATA, MEM_RDATA;
    logic [25:0] cap;
    logic [2:0] lat = 3'h0;
    int acks = 0;
    bit mem_on = 1'b0;
    int num_errors = 0, checks_done = 0;
    logic [7:0] rq[$];
    logic [7:0] ref_mem[int];
    always #12.5 CLK_SYS = ~CLK_SYS;
    always @(posedge CLK_SYS) TX_READY <= ($urandom % 4) != 0;
    always @(posedge CLK_SYS) begin
        if (TX_VALID === 1'b1 && TX_READY === 1'b1) rq.push_back(TX_DATA);
        if (MEM_ACK === 1'b1) begin
            cap = {MEM_WE, MEM_BANK, MEM_ROW, MEM_COL};
            acks++;
        end
    end
    pmac_core #(.INIT_CYCLES(4)) uut (.CLK_SYS(CLK_SYS), .RST(RST), .RX_VALID(RX_VALID),
        .RX_DATA(RX_DATA), .RX_READY(RX_READY), .TX_VALID(TX_VALID), .TX_DATA(TX_DATA),
        .TX_READY(TX_READY), .MEM_REQ(MEM_REQ), .MEM_WE(MEM_WE), .MEM_BANK(MEM_BANK),
        .MEM_ROW(MEM_ROW), .MEM_COL(MEM_COL), .MEM_WDATA(MEM_WDATA), .MEM_ACK(MEM_ACK),
        .MEM_RDATA(MEM_RDATA), .MEM_READY(MEM_READY));
    pmac_mem mem (.clk(CLK_SYS), .rst(RST), .lat(lat), .req(MEM_REQ), .we(MEM_WE),
        .bank(MEM_BANK), .row(MEM_ROW), .col(MEM_COL), .wdata(MEM_WDATA), .ack(MEM_ACK),
        .rdata(MEM_RDATA));
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        checks_done++;
        if (got !== exp) begin
            num_errors++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    task automatic put(input logic [7:0] b);
        RX_VALID <= 1'b1;
        RX_DATA <= b;
        do @(posedge CLK_SYS); while (RX_READY !== 1'b1);
    endtask : put
    task automatic op(input bit wr, input logic [1:0] bk, input logic [12:0] rw,
                      input logic [9:0] c, input logic [31:0] d);
        logic [7:0] pk[8];
        logic [7:0] ex[$];
        int a;
        int n;
        int a0;
        bit rdy;
        rdy = mem_on;
        a0 = acks;
        pk[0] = {wr ? 4'h9 : 4'h8, 3'h0, rw[12]};
        pk[1] = rw[11:4];
        pk[2] = {rw[3:0], c[9:6]};
        pk[3] = {c[5:0], bk};
        for (int k = 0; k < 4; k++) pk[4+k] = d[8*k +: 8];
        lat <= 3'($urandom % 6);
        rq.delete();
        for (int k = 0; k < (wr ? 8 : 4); k++) put(pk[k]);
        RX_VALID <= 1'b0;
        if (!wr) ex.push_back(rdy ? pk[0] : 8'he7);
        for (int k = 0; k < 4; k++) begin
            a = {bk, rw, c[9:2], 2'(c[1:0] + 2'(k))};
            if (wr && rdy) ref_mem[a] = d[8*k +: 8];
            if (wr) ex.push_back(d[8*k +: 8]);
            else ex.push_back(rdy && ref_mem.exists(a) ? ref_mem[a] : 8'h00);
        end
        if (wr) ex.push_back(rdy ? pk[0] : 8'he7);
        for (int k = 1; k < 4 && wr; k++) ex.push_back(pk[k]);
        n = 0;
        while (rq.size() < ex.size() && n < 300) begin
            @(posedge CLK_SYS);
            n++;
        end
        repeat (8) @(posedge CLK_SYS);
        chk("reply length", ex.size(), rq.size());
        chk("memory accesses", rdy ? 1 : 0, acks - a0);
        for (int k = 0; k < ex.size(); k++) chk("reply byte", ex[k], rq[k]);
        if (rdy) chk("memory address", {wr, bk, rw, c}, cap);
    endtask : op
    task automatic conclude;
        $display("checks %0d errors %0d", checks_done, num_errors);
        if (num_errors == 0 && checks_done > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : conclude
    initial begin
        repeat (20000) @(posedge CLK_SYS);
        num_errors++;
        conclude;
    end
    initial begin
        void'($urandom(63227));
        repeat (20) @(posedge CLK_SYS);
        RST <= 1'b0;
        @(posedge CLK_SYS);
        op(0, 2'h1, 13'h1abc, 10'h2f5, 32'h0);
        op(1, 2'h2, 13'h0123, 10'h014, 32'h44332211);
        rq.delete();
        put(8'h20);
        RX_VALID <= 1'b0;
        repeat (8) @(posedge CLK_SYS);
        chk("ignored reply", 0, rq.size());
        chk("ready before init", 1'b0, MEM_READY);
        put(8'h70);
        RX_VALID <= 1'b0;
        repeat (3) @(posedge CLK_SYS);
        chk("ready during init", 1'b0, MEM_READY);
        repeat (3) @(posedge CLK_SYS);
        chk("ready after init", 1'b1, MEM_READY);
        mem_on = 1'b1;
        op(1, 2'h3, 13'h1fff, 10'h3fc, 32'hd3d2d1d0);
        op(1, 2'h3, 13'h1fff, 10'h3fd, 32'ha3a2a1a0);
        op(0, 2'h3, 13'h1fff, 10'h3fc, 32'h0);
        op(0, 2'h3, 13'h1fff, 10'h3fe, 32'h0);
        for (int i = 0; i < 60; i++)
            op($urandom % 2, 2'($urandom), 13'($urandom % 3) << 12, 10'($urandom % 8), $urandom);
        // Reset in mid-run must drop the initialised state
        RST <= 1'b1;
        repeat (3) @(posedge CLK_SYS);
        RST <= 1'b0;
        mem_on = 1'b0;
        @(posedge CLK_SYS);
        chk("ready after reset", 1'b0, MEM_READY);
        op(1, 2'h1, 13'h0040, 10'h008, 32'h5a6b7c8d);
        conclude;
    end
endmodule : tb
bind pmac_core pmac_chk #(.INIT_CYCLES(INIT_CYCLES)) u_chk (.CLK_SYS(CLK_SYS), .RST(RST),
    .RX_READY(RX_READY), .TX_VALID(TX_VALID), .TX_DATA(TX_DATA), .TX_READY(TX_READY),
    .MEM_REQ(MEM_REQ), .MEM_WE(MEM_WE), .MEM_ROW(MEM_ROW), .MEM_COL(MEM_COL),
    .MEM_WDATA(MEM_WDATA), .MEM_ACK(MEM_ACK), .MEM_READY(MEM_READY));
